// ---- bench/eeprom_group_ecc_bench.sv ----
// self-checking bench for the group ecc engine
`timescale 1ns/1ps
module eeprom_group_ecc_bench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic rd_req, rd_valid, wr_byte, wr_commit, busy, cyc_start;
    logic [eg_pkg::ADDR_W-1:0] rd_addr;
    eg_pkg::eg_wr_s wr;
    eg_pkg::eg_rd_s rd;
    logic [7:0] pulses;
    int errors = 0;
    int n_tests = 0;
    // short hold count keeps the run brief
    eg_ecc_core #(.T_WR_CYCLES(17'h00014)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rd_req_in(rd_req),
        .rd_addr_in(rd_addr), .rd_out(rd), .rd_valid_out(rd_valid), .wr_byte_in(wr_byte), .wr_in(wr),
        .wr_commit_in(wr_commit), .busy_out(busy), .cycle_start_out(cyc_start));
    eg_host_model host (.clk_sys_in(clk_sys_in), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
        .wr_byte_out(wr_byte), .wr_out(wr), .wr_commit_out(wr_commit), .cycle_start_in(cyc_start));
    always #20 clk_sys_in = ~clk_sys_in;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // counts extra start pulses; the first one is checked by the caller
    task automatic wait_idle();
        int i;
        pulses = 8'h00;
        for (i = 0; i < 300 && busy !== 1'b0; i++) begin
            @(posedge clk_sys_in);
            #1;
            if (cyc_start === 1'b1) pulses++;
        end
        if (i == 300) begin
            errors++;
            $display("[FAIL] %0t: program cycle never ended", $time);
            end_of_test();
        end
    endtask
    task automatic commit_wait();
        host.commit();
        check({7'h00, busy}, 8'h01);
        check({7'h00, cyc_start}, 8'h01);
        wait_idle();
        check(pulses, 8'h00);
    endtask
    task automatic read_expect(input logic [15:0] a, input logic [7:0] exp);
        int i;
        host.pulse_read(a);
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
            @(posedge clk_sys_in);
            #1;
        end
        check(8'(i), 8'h01);
        check(rd.data, exp);
        check({7'h00, rd.corrected}, 8'h00);
        if (i == 4) end_of_test();
    endtask
    task automatic t_fill();
        for (int k = 0; k < 8; k++) host.put_byte(16'(k), 8'ha0 + 8'(k));
        commit_wait();
        for (int k = 0; k < 8; k++) read_expect(16'(k), 8'ha0 + 8'(k));
        $display("test group fill done");
    endtask
    task automatic t_single();
        host.put_byte(16'h0005, 8'h5a);
        commit_wait();
        for (int k = 4; k < 8; k++) read_expect(16'(k), (k == 5) ? 8'h5a : 8'ha0 + 8'(k));
        $display("test single byte done");
    endtask
    task automatic t_busy();
        host.put_byte(16'h0006, 8'hc3);
        host.commit();
        host.pulse_read(16'h0004);
        repeat (3) begin
            @(posedge clk_sys_in);
            #1;
            check({7'h00, rd_valid}, 8'h00);
        end
        host.put_byte(16'h0007, 8'hee);
        wait_idle();
        commit_wait();
        read_expect(16'h0006, 8'hc3);
        read_expect(16'h0007, 8'ha7);
        $display("test busy refusal done");
    endtask
    // reset in mid program cycle: outputs clear, array keeps old groups
    task automatic t_reset();
        host.put_byte(16'h0004, 8'h11);
        host.commit();
        @(negedge clk_sys_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        check({7'h00, busy}, 8'h00);
        check({7'h00, cyc_start}, 8'h00);
        check({7'h00, rd_valid}, 8'h00);
        check(rd.data, 8'h00);
        read_expect(16'h0000, 8'ha0);
        $display("test mid-run reset done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        t_fill();
        t_single();
        t_busy();
        t_reset();
        check(8'(host.grp_cycles), 8'h05);
        end_of_test();
    end
endmodule

// ---- bench/eg_ecc_monitor.sv ----
// assertion checker for the group ecc engine ports
`timescale 1ns/1ps
module eg_ecc_monitor #(
    parameter logic [eg_pkg::WR_CNT_W-1:0] T_WR_CYCLES = 17'h00014
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // watched ports
    input wire logic rd_req_in,
    input wire logic rd_valid_out,
    input wire logic wr_commit_in,
    input wire logic busy_out,
    input wire logic cycle_start_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    AST_RD_CAUSE: assert property (rd_valid_out |-> $past(rd_req_in, 2))
        else $error("read answer without request two cycles before");
    AST_RD_PULSE: assert property (rd_valid_out |=> !rd_valid_out)
        else $error("read valid longer than one cycle");
    AST_START_BUSY: assert property (cycle_start_out |-> busy_out[*8])
        else $error("busy dropped early in program cycle");
    AST_START_PULSE: assert property (cycle_start_out |=> !cycle_start_out)
        else $error("cycle start longer than one cycle");
    AST_BUSY_START: assert property ($rose(busy_out) |-> cycle_start_out)
        else $error("busy rose without cycle start");
    AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(wr_commit_in))
        else $error("busy rose without commit");
    AST_COMMIT_TAKEN: assert property (wr_commit_in && !busy_out && !$past(busy_out) && !$past(rd_req_in)
        |=> busy_out && cycle_start_out)
        else $error("idle commit did not start a program cycle");
    AST_BUSY_NO_READ: assert property (rd_req_in && busy_out |-> ##2 !rd_valid_out)
        else $error("read answered while programming");
    // busy length counter; too long for a repetition count
    logic [eg_pkg::WR_CNT_W-1:0] busy_len;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !busy_out) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy_len + 1'b1;
        end
    end
    AST_BUSY_LEN: assert property ($fell(busy_out) |-> busy_len >= T_WR_CYCLES + eg_pkg::WR_CNT_W'(1 << eg_pkg::PAGE_GRP_W))
        else $error("busy shorter than group scan plus hold time");
endmodule
bind eg_ecc_core eg_ecc_monitor #(.T_WR_CYCLES(T_WR_CYCLES)) u_monitor (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out), .wr_commit_in(wr_commit_in),
    .busy_out(busy_out), .cycle_start_out(cycle_start_out));

// ---- bench/eg_host_model.sv ----
// host-side model: drives request pulses into the ecc engine
`timescale 1ns/1ps
module eg_host_model (
    // clock
    input wire logic clk_sys_in,
    // requests
    output logic rd_req_out,
    output logic [eg_pkg::ADDR_W-1:0] rd_addr_out,
    output logic wr_byte_out,
    output eg_pkg::eg_wr_s wr_out,
    output logic wr_commit_out,
    // status
    input wire logic cycle_start_in
);
    int unsigned grp_cycles = 0;
    initial begin
        rd_req_out = 1'b0;
        rd_addr_out = 16'h0000;
        wr_byte_out = 1'b0;
        wr_out = 24'h000000;
        wr_commit_out = 1'b0;
    end
    // endurance is budgeted per group, so one program cycle is one count
    always @(posedge clk_sys_in) begin
        if (cycle_start_in === 1'b1) grp_cycles <= grp_cycles + 1;
    end
    // released lines flip, so a stale value never reads as valid
    task automatic pulse_read(input logic [15:0] a);
        @(negedge clk_sys_in);
        rd_req_out = 1'b1;
        rd_addr_out = a;
        @(negedge clk_sys_in);
        rd_req_out = 1'b0;
        rd_addr_out = ~a;
    endtask
    task automatic put_byte(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        wr_byte_out = 1'b1;
        wr_out = {a, d};
        @(negedge clk_sys_in);
        wr_byte_out = 1'b0;
        wr_out = ~{a, d};
    endtask
    task automatic commit();
        @(negedge clk_sys_in);
        wr_commit_out = 1'b1;
        @(negedge clk_sys_in);
        wr_commit_out = 1'b0;
    endtask
endmodule

// ---- verilog/eg_ecc_core.sv ----
// group ecc engine: corrected reads and whole-group program cycles
`timescale 1ns/1ps
module eg_ecc_core #(
    parameter logic [eg_pkg::WR_CNT_W-1:0] T_WR_CYCLES = eg_pkg::WR_CNT_W'(eg_pkg::WR_CYCLES)
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // read request from the bus front end
    input wire logic rd_req_in,
    input wire logic [eg_pkg::ADDR_W-1:0] rd_addr_in,
    output eg_pkg::eg_rd_s rd_out,
    output logic rd_valid_out,
    // write bytes and commit at stop
    input wire logic wr_byte_in,
    input wire eg_pkg::eg_wr_s wr_in,
    input wire logic wr_commit_in,
    // status to the bus front end
    output logic busy_out,
    output logic cycle_start_out
);
    typedef enum logic [2:0] {
        EG_IDLE = 3'h0,
        EG_RD_WAIT = 3'h1,
        EG_PG_SCAN = 3'h2,
        EG_PG_MERGE = 3'h3,
        EG_PG_HOLD = 3'h4
    } eg_state_e;

    function automatic logic [eg_pkg::CHK_W-1:0] eg_syndrome(input logic [eg_pkg::CW_W-1:0] cw);
        logic [eg_pkg::CHK_W-1:0] syn;
        syn = '0;
        for (int p = 1; p <= eg_pkg::CW_W; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ eg_pkg::CHK_W'(p);
            end
        end
        return syn;
    endfunction

    function automatic logic [eg_pkg::CW_W-1:0] eg_encode(input logic [eg_pkg::DATA_W-1:0] d);
        logic [eg_pkg::CW_W-1:0] cw;
        logic [eg_pkg::CHK_W-1:0] syn;
        int j;
        cw = '0;
        j = 0;
        for (int p = 1; p <= eg_pkg::CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[j];
                j++;
            end
        end
        syn = eg_syndrome(cw);
        for (int k = 0; k < eg_pkg::CHK_W; k++) begin
            cw[(1 << k) - 1] = syn[k];
        end
        return cw;
    endfunction

    // returns {flag, data}; the flag is set when a bit was flipped back
    function automatic logic [eg_pkg::DATA_W:0] eg_decode(input logic [eg_pkg::CW_W-1:0] cw_in);
        logic [eg_pkg::CW_W-1:0] cw;
        logic [eg_pkg::CHK_W-1:0] syn;
        logic [eg_pkg::DATA_W-1:0] d;
        logic flag;
        int j;
        cw = cw_in;
        syn = eg_syndrome(cw);
        flag = 1'b0;
        d = '0;
        j = 0;
        if (syn != '0 && syn <= eg_pkg::CHK_W'(eg_pkg::CW_W)) begin
            cw[syn-1] = ~cw[syn-1];
            flag = 1'b1;
        end
        for (int p = 1; p <= eg_pkg::CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = cw[p-1];
                j++;
            end
        end
        return {flag, d};
    endfunction

    eg_state_e state;
    eg_state_e next_state;
    logic [eg_pkg::PAGE_GRP_W-1:0] grp_idx;
    logic [eg_pkg::PAGE_GRP_W-1:0] next_grp_idx;
    logic [eg_pkg::PAGE_BASE_W-1:0] pg_base;
    logic [eg_pkg::PAGE_BASE_W-1:0] next_pg_base;
    logic [7:0] pg_data [eg_pkg::PAGE_BYTES];
    logic [7:0] next_pg_data [eg_pkg::PAGE_BYTES];
    logic [eg_pkg::PAGE_BYTES-1:0] pg_mask;
    logic [eg_pkg::PAGE_BYTES-1:0] next_pg_mask;
    logic [eg_pkg::WR_CNT_W-1:0] cnt;
    logic [eg_pkg::WR_CNT_W-1:0] next_cnt;
    logic [eg_pkg::LANE_W-1:0] rd_lane;
    logic [eg_pkg::LANE_W-1:0] next_rd_lane;
    eg_pkg::eg_rd_s next_rd_out;
    logic next_rd_valid;
    logic next_busy;
    logic next_cycle_start;
    logic mem_en;
    logic mem_we;
    logic [eg_pkg::GRP_AW-1:0] mem_addr;
    logic [eg_pkg::CW_W-1:0] mem_wdata;
    logic [eg_pkg::CW_W-1:0] mem_rdata;

    eg_group_mem u_mem (
        .clk_sys_in(clk_sys_in),
        .en_in(mem_en),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        logic [eg_pkg::DATA_W:0] dec;
        logic [eg_pkg::DATA_W-1:0] merged;
        logic [eg_pkg::PAGE_AW-1:0] pidx;
        dec = eg_decode(mem_rdata);
        merged = dec[eg_pkg::DATA_W-1:0];
        pidx = '0;
        next_state = state;
        next_grp_idx = grp_idx;
        next_pg_base = pg_base;
        next_pg_data = pg_data;
        next_pg_mask = pg_mask;
        next_cnt = cnt;
        next_rd_lane = rd_lane;
        next_rd_out = rd_out;
        next_rd_valid = 1'b0;
        next_cycle_start = 1'b0;
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = {pg_base, grp_idx};
        mem_wdata = '0;
        unique case (state)
            EG_IDLE: begin
                // page address wraps inside the page, later bytes overwrite
                if (wr_byte_in) begin
                    next_pg_base = wr_in.addr[eg_pkg::ADDR_W-1:eg_pkg::PAGE_AW];
                    next_pg_data[wr_in.addr[eg_pkg::PAGE_AW-1:0]] = wr_in.data;
                    next_pg_mask[wr_in.addr[eg_pkg::PAGE_AW-1:0]] = 1'b1;
                end
                if (wr_commit_in) begin
                    next_state = EG_PG_SCAN;
                    next_grp_idx = '0;
                    next_cycle_start = 1'b1;
                end else if (rd_req_in) begin
                    mem_en = 1'b1;
                    mem_addr = rd_addr_in[eg_pkg::ADDR_W-1:eg_pkg::LANE_W];
                    next_rd_lane = rd_addr_in[eg_pkg::LANE_W-1:0];
                    next_state = EG_RD_WAIT;
                end
            end
            EG_RD_WAIT: begin
                next_rd_out.data = dec[8*rd_lane +: 8];
                next_rd_out.corrected = dec[eg_pkg::DATA_W];
                next_rd_valid = 1'b1;
                next_state = EG_IDLE;
            end
            EG_PG_SCAN: begin
                // untouched groups are skipped and keep their wear
                if (pg_mask[4*grp_idx +: eg_pkg::GROUP_BYTES] != '0) begin
                    mem_en = 1'b1;
                    next_state = EG_PG_MERGE;
                end else if (grp_idx == '1) begin
                    next_state = EG_PG_HOLD;
                end else begin
                    next_grp_idx = grp_idx + 1'b1;
                end
            end
            EG_PG_MERGE: begin
                for (int k = 0; k < eg_pkg::GROUP_BYTES; k++) begin
                    pidx = {grp_idx, eg_pkg::LANE_W'(k)};
                    if (pg_mask[pidx]) begin
                        merged[8*k +: 8] = pg_data[pidx];
                    end
                end
                mem_en = 1'b1;
                mem_we = 1'b1;
                mem_wdata = eg_encode(merged);
                if (grp_idx == '1) begin
                    next_state = EG_PG_HOLD;
                end else begin
                    next_grp_idx = grp_idx + 1'b1;
                    next_state = EG_PG_SCAN;
                end
            end
            EG_PG_HOLD: begin
                // models the slow cell programming time
                next_pg_mask = '0;
                if (cnt >= T_WR_CYCLES - 1'b1) begin
                    next_cnt = '0;
                    next_state = EG_IDLE;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: begin
                next_state = EG_IDLE;
            end
        endcase
        next_busy = (next_state == EG_PG_SCAN) || (next_state == EG_PG_MERGE) ||
                    (next_state == EG_PG_HOLD);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= EG_IDLE;
            grp_idx <= '0;
            pg_base <= '0;
            pg_mask <= '0;
            cnt <= '0;
            rd_lane <= '0;
            rd_out <= '0;
            rd_valid_out <= 1'b0;
            busy_out <= 1'b0;
            cycle_start_out <= 1'b0;
        end else begin
            state <= next_state;
            grp_idx <= next_grp_idx;
            pg_base <= next_pg_base;
            pg_mask <= next_pg_mask;
            cnt <= next_cnt;
            rd_lane <= next_rd_lane;
            rd_out <= next_rd_out;
            rd_valid_out <= next_rd_valid;
            busy_out <= next_busy;
            cycle_start_out <= next_cycle_start;
        end
    end

    // byte staging needs no reset, the mask guards it
    always_ff @(posedge clk_sys_in) begin
        pg_data <= next_pg_data;
    end
endmodule

// ---- verilog/eg_group_mem.sv ----
// group array: one ecc codeword per four-byte group, registered read
`timescale 1ns/1ps
module eg_group_mem (
    // clock
    input wire logic clk_sys_in,
    // access port
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [eg_pkg::GRP_AW-1:0] addr_in,
    input wire logic [eg_pkg::CW_W-1:0] wdata_in,
    output logic [eg_pkg::CW_W-1:0] rdata_out
);
    logic [eg_pkg::CW_W-1:0] mem [eg_pkg::GROUP_COUNT];

    always_ff @(posedge clk_sys_in) begin
        if (en_in && we_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (en_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule

// ---- verilog/eg_pkg.sv ----
// shared constants and carriers for the group ecc engine
package eg_pkg;
    localparam int ADDR_W = 16;
    localparam int GRP_AW = 14;
    localparam int GROUP_COUNT = 16384;
    localparam int GROUP_BYTES = 4;
    localparam int LANE_W = 2;
    localparam int DATA_W = 32;
    localparam int CHK_W = 6;
    localparam int CW_W = 38;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_AW = 7;
    localparam int PAGE_GRP_W = 5;
    localparam int PAGE_BASE_W = 9;
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_WR_NS = 5000000;
    localparam int WR_CNT_W = 17;
    localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } eg_wr_s;

    typedef struct packed {
        logic [7:0] data;
        logic corrected;
    } eg_rd_s;
endpackage
